// ---- logic/ctd_pkg.sv ----
// Purpose: shared constants and types for the capacitive touch detect core
// Assumes: 25 MHz reference clock
// Notes: timing figures are stated in their own unit and converted to cycles here
package ctd_pkg;

    // ----------------------------------------
    // clock and timing
    // ----------------------------------------
    localparam int CLK_HZ = 25000000;
    // nominal timing oscillator frequency, Hz
    localparam int OSC_HZ = 2000;
    localparam int OSC_HALF_CYC = CLK_HZ / (OSC_HZ * 2);
    // modulation depth, percent
    localparam int MOD_PCT = 4;
    localparam int MOD_SPAN_CYC = (OSC_HALF_CYC * MOD_PCT) / 100;
    // correction pulse width, ns
    localparam int UP_PULSE_NS = 4000;
    localparam int DN_PULSE_NS = 3000;
    localparam int UP_PULSE_CYC = (UP_PULSE_NS * 25 + 999) / 1000;
    localparam int DN_PULSE_CYC = (DN_PULSE_NS * 25 + 999) / 1000;
    // pulse mode output time, us
    localparam int PULSE_OUT_US = 10000;
    localparam int PULSE_OUT_CYC = PULSE_OUT_US * 25;
    // run length to declare an event
    localparam int RUN_THRESHOLD = 8;
    // lfsr seed
    localparam logic [7:0] LFSR_SEED = 8'ha5;

    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic [1:0]
    {
        MODE_PUSH = 2'b00,
        MODE_TOGGLE = 2'b01,
        MODE_PULSE = 2'b10
    } ctd_mode_type;

    typedef struct packed
    {
        logic up;
        logic down;
    } ctd_dir_type;

endpackage

// ---- logic/ctd_osc.sv ----
// Purpose: dithered sample timing generator
// Assumes: single clock, synchronous active low reset
// Notes: emits a sample strobe every two oscillator half periods
`timescale 1ns/1ps
module ctd_osc #(
    parameter int HALF_CYC = ctd_pkg::OSC_HALF_CYC,
    parameter int SPAN_CYC = (HALF_CYC * ctd_pkg::MOD_PCT) / 100
)
(
    input wire logic clk,
    input wire logic nrst,
    output logic charge,
    output logic sample
);

    logic [7:0] lfsr_reg;
    logic [19:0] cnt_reg;
    logic [19:0] limit;
    logic phase_reg;

    // ----------------------------------------
    // pseudo random dither
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (!nrst)
            lfsr_reg <= ctd_pkg::LFSR_SEED;
        else if (cnt_reg == 20'h0)
            lfsr_reg <= {lfsr_reg[6:0], lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]};
    end

    // limit moves within +-span around nominal
    always_comb
    begin
        limit = 20'(HALF_CYC - SPAN_CYC) + 20'((SPAN_CYC * 2 * int'(lfsr_reg)) / 255);
    end

    // ----------------------------------------
    // half period counter
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (!nrst)
            cnt_reg <= 20'h0;
        else if (cnt_reg == 20'h0)
            cnt_reg <= limit - 20'h1;
        else
            cnt_reg <= cnt_reg - 20'h1;
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            phase_reg <= 1'b0;
            charge <= 1'b0;
            sample <= 1'b0;
        end
        else
        begin
            sample <= 1'b0;
            if (cnt_reg == 20'h0)
            begin
                phase_reg <= ~phase_reg;
                charge <= ~phase_reg;
                sample <= phase_reg;
            end
        end
    end

    property p_sample_rate;
        @(posedge clk) disable iff (!nrst) sample |-> !charge && $past(charge);
    endproperty
    a_sample_rate: assert property (p_sample_rate) else $error("sample strobe off phase");

endmodule

// ---- logic/ctd_pulse_gen.sv ----
// Purpose: fixed width correction pulse generator
// Assumes: start arrives as a one cycle strobe
// Notes: a start while busy is dropped
`timescale 1ns/1ps
module ctd_pulse_gen #(
    parameter int WIDTH_CYC = ctd_pkg::UP_PULSE_CYC
)
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic start,
    output logic active
);

    logic [15:0] cnt_reg;

    // ----------------------------------------
    // width counter
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            cnt_reg <= 16'h0;
            active <= 1'b0;
        end
        else if (start && !active)
        begin
            cnt_reg <= 16'(WIDTH_CYC - 1);
            active <= 1'b1;
        end
        else if (cnt_reg != 16'h0)
            cnt_reg <= cnt_reg - 16'h1;
        else
            active <= 1'b0;
    end

endmodule

// ---- logic/ctd_core.sv ----
// Purpose: capacitive touch detect core
// Assumes: comparator outputs and overcurrent flag are asynchronous pins
// Notes: output is active high inside the block
`timescale 1ns/1ps
module ctd_core #(
    parameter int THRESHOLD = ctd_pkg::RUN_THRESHOLD,
    parameter int PULSE_OUT_CYC = ctd_pkg::PULSE_OUT_CYC,
    parameter int OSC_HALF_CYC = ctd_pkg::OSC_HALF_CYC
)
(
    input wire logic REF_CLK,
    input wire logic NRST,
    input wire logic SENSE_CMP_N,
    input wire logic REF_CMP_N,
    input wire logic OVERCURRENT,
    input wire ctd_pkg::ctd_mode_type MODE,
    output logic CHARGE_SENSE,
    output logic CHARGE_REF,
    output logic SAMPLE_RATE_CAPACITOR_NODE,
    output logic SENS_CAP_CHARGE,
    output logic SENS_CAP_SINK,
    output ctd_pkg::ctd_dir_type LAST_PULSE,
    output logic SWITCH_OUT
);

    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b00,
        ST_RACE = 2'b01,
        ST_DONE = 2'b10
    } ctd_race_type;

    logic [1:0] sense_sync_reg;
    logic [1:0] ref_sync_reg;
    logic [1:0] oc_sync_reg;
    logic charge;
    logic sample;
    ctd_race_type race_reg;
    logic up_pulse;
    logic down_pulse;
    logic up_active;
    logic down_active;
    logic [7:0] run_reg;
    logic last_up_reg;
    logic event_reg;
    logic event_prev_reg;
    logic started_reg;
    logic [23:0] hold_reg;
    logic out_reg;
    logic event_rise;
    logic [7:0] up_len_reg;
    logic [7:0] dn_len_reg;

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    always_ff @(posedge REF_CLK)
    begin
        if (!NRST)
        begin
            sense_sync_reg <= 2'b11;
            ref_sync_reg <= 2'b11;
            oc_sync_reg <= 2'b00;
        end
        else
        begin
            sense_sync_reg <= {sense_sync_reg[0], SENSE_CMP_N};
            ref_sync_reg <= {ref_sync_reg[0], REF_CMP_N};
            oc_sync_reg <= {oc_sync_reg[0], OVERCURRENT};
        end
    end

    // ----------------------------------------
    // sample timing
    // ----------------------------------------
    ctd_osc #(.HALF_CYC(OSC_HALF_CYC)) u_osc (
        .clk(REF_CLK),
        .nrst(NRST),
        .charge(charge),
        .sample(sample)
    );

    always_ff @(posedge REF_CLK)
    begin
        if (!NRST)
        begin
            CHARGE_SENSE <= 1'b0;
            CHARGE_REF <= 1'b0;
            SAMPLE_RATE_CAPACITOR_NODE <= 1'b0;
        end
        else
        begin
            CHARGE_SENSE <= charge;
            CHARGE_REF <= charge;
            SAMPLE_RATE_CAPACITOR_NODE <= charge;
        end
    end

    // ----------------------------------------
    // discharge race
    // ----------------------------------------
    always_ff @(posedge REF_CLK)
    begin
        if (!NRST)
            race_reg <= ST_IDLE;
        else
        begin
            case (race_reg)
                ST_IDLE: if (sample) race_reg <= ST_RACE;
                ST_RACE:
                    if (charge)
                        race_reg <= ST_IDLE;
                    else if (!ref_sync_reg[1] || !sense_sync_reg[1])
                        race_reg <= ST_DONE;
                ST_DONE: if (charge) race_reg <= ST_IDLE;
                default: race_reg <= ST_IDLE;
            endcase
        end
    end

    // reference wins ties toward up; sensor alone gives down
    assign up_pulse = (race_reg == ST_RACE) && !charge && !ref_sync_reg[1];
    assign down_pulse = (race_reg == ST_RACE) && !charge
        && !sense_sync_reg[1] && ref_sync_reg[1];

    // ----------------------------------------
    // charge correction pulses
    // ----------------------------------------
    ctd_pulse_gen #(.WIDTH_CYC(ctd_pkg::UP_PULSE_CYC)) u_up (
        .clk(REF_CLK),
        .nrst(NRST),
        .start(up_pulse),
        .active(up_active)
    );

    ctd_pulse_gen #(.WIDTH_CYC(ctd_pkg::DN_PULSE_CYC)) u_dn (
        .clk(REF_CLK),
        .nrst(NRST),
        .start(down_pulse),
        .active(down_active)
    );

    always_ff @(posedge REF_CLK)
    begin
        if (!NRST)
        begin
            SENS_CAP_CHARGE <= 1'b0;
            SENS_CAP_SINK <= 1'b0;
            LAST_PULSE <= '0;
        end
        else
        begin
            SENS_CAP_CHARGE <= up_active;
            SENS_CAP_SINK <= down_active;
            if (up_pulse || down_pulse)
                LAST_PULSE <= '{up: up_pulse, down: down_pulse};
        end
    end

    // ----------------------------------------
    // run counter
    // ----------------------------------------
    always_ff @(posedge REF_CLK)
    begin
        if (!NRST)
        begin
            run_reg <= 8'h0;
            last_up_reg <= 1'b0;
            started_reg <= 1'b0;
        end
        else if (up_pulse || down_pulse)
        begin
            started_reg <= 1'b1;
            last_up_reg <= up_pulse;
            if (started_reg && (up_pulse != last_up_reg))
                run_reg <= 8'h1;
            else if (run_reg != 8'hff)
                run_reg <= run_reg + 8'h1;
        end
    end

    // ----------------------------------------
    // event detection
    // ----------------------------------------
    always_ff @(posedge REF_CLK)
    begin
        if (!NRST)
        begin
            event_reg <= 1'b0;
            event_prev_reg <= 1'b0;
        end
        else
        begin
            event_prev_reg <= event_reg;
            if (run_reg >= 8'(THRESHOLD))
                event_reg <= last_up_reg;
        end
    end

    assign event_rise = event_reg && !event_prev_reg;

    // ----------------------------------------
    // output modes
    // ----------------------------------------
    always_ff @(posedge REF_CLK)
    begin
        if (!NRST)
        begin
            out_reg <= 1'b0;
            hold_reg <= 24'h0;
        end
        else
        begin
            case (MODE)
                ctd_pkg::MODE_PUSH: out_reg <= event_reg;
                ctd_pkg::MODE_TOGGLE: if (event_rise) out_reg <= ~out_reg;
                ctd_pkg::MODE_PULSE:
                    if (hold_reg != 24'h0)
                        hold_reg <= hold_reg - 24'h1;
                    else if (out_reg)
                        out_reg <= 1'b0;
                    else if (event_rise)
                    begin
                        out_reg <= 1'b1;
                        hold_reg <= 24'(PULSE_OUT_CYC - 1);
                    end
                default: out_reg <= 1'b0;
            endcase
        end
    end

    always_ff @(posedge REF_CLK)
    begin
        if (!NRST)
            SWITCH_OUT <= 1'b0;
        else
            SWITCH_OUT <= out_reg && !oc_sync_reg[1];
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    // pulse width counters for the checks below
    always_ff @(posedge REF_CLK)
    begin
        up_len_reg <= (NRST && up_active) ? up_len_reg + 8'h1 : 8'h0;
        dn_len_reg <= (NRST && down_active) ? dn_len_reg + 8'h1 : 8'h0;
    end

    property p_same_charge;
        @(posedge REF_CLK) disable iff (!NRST) CHARGE_SENSE == CHARGE_REF;
    endproperty
    a_same_charge: assert property (p_same_charge) else $error("charge mismatch");

    property p_up_win;
        @(posedge REF_CLK) disable iff (!NRST) up_pulse |-> ##2 SENS_CAP_CHARGE;
    endproperty
    a_up_win: assert property (p_up_win) else $error("up pulse missing");

    property p_dn_win;
        @(posedge REF_CLK) disable iff (!NRST) down_pulse && !down_active |-> ##2 SENS_CAP_SINK;
    endproperty
    a_dn_win: assert property (p_dn_win) else $error("down pulse missing");

    property p_excl;
        @(posedge REF_CLK) disable iff (!NRST) !(up_pulse && down_pulse);
    endproperty
    a_excl: assert property (p_excl) else $error("both pulses at once");

    property p_up_width;
        @(posedge REF_CLK) disable iff (!NRST)
            $fell(up_active) |-> up_len_reg == 8'(ctd_pkg::UP_PULSE_CYC);
    endproperty
    a_up_width: assert property (p_up_width) else $error("up pulse too short");

    property p_dn_width;
        @(posedge REF_CLK) disable iff (!NRST)
            $fell(down_active) |-> dn_len_reg == 8'(ctd_pkg::DN_PULSE_CYC);
    endproperty
    a_dn_width: assert property (p_dn_width) else $error("down pulse too short");

    property p_clear;
        @(posedge REF_CLK) disable iff (!NRST)
            (up_pulse && started_reg && !last_up_reg) |=> run_reg == 8'h1;
    endproperty
    a_clear: assert property (p_clear) else $error("run not cleared");

    property p_count;
        @(posedge REF_CLK) disable iff (!NRST)
            (up_pulse && last_up_reg && run_reg < 8'h10) |=> run_reg == $past(run_reg) + 8'h1;
    endproperty
    a_count: assert property (p_count) else $error("run not counted");

    property p_oc;
        @(posedge REF_CLK) disable iff (!NRST) oc_sync_reg[1] |=> !SWITCH_OUT;
    endproperty
    a_oc: assert property (p_oc) else $error("output on in overcurrent");

    property p_thresh;
        @(posedge REF_CLK) disable iff (!NRST)
            $rose(event_reg) |-> $past(run_reg) >= 8'(THRESHOLD);
    endproperty
    a_thresh: assert property (p_thresh) else $error("event before threshold");

    property p_push;
        @(posedge REF_CLK) disable iff (!NRST)
            (MODE == ctd_pkg::MODE_PUSH) |=> out_reg == $past(event_reg);
    endproperty
    a_push: assert property (p_push) else $error("push mode mismatch");

    c_up: cover property (@(posedge REF_CLK) up_pulse);
    c_down: cover property (@(posedge REF_CLK) down_pulse);
    c_event: cover property (@(posedge REF_CLK) event_rise);
    c_out: cover property (@(posedge REF_CLK) $rose(SWITCH_OUT));

endmodule

// ---- dv/ctd_rc_model.sv ----
// Purpose: behavioural model of the sensor and reference rc comparators
// Assumes: outputs are low while the node sits below the reference level
// Notes: ref_first picks which comparator falls first in a discharge phase
`timescale 1ns/1ps
module ctd_rc_model #(
    parameter int WIN_CYC = 200,
    parameter int LOSE_CYC = 900
)
(
    input wire logic clk,
    input wire logic charge_sense,
    input wire logic charge_ref,
    input wire logic ref_first,
    output logic sense_cmp_n,
    output logic ref_cmp_n
);
    // ----------------------------------------
    // discharge race
    // ----------------------------------------
    int dis_cnt;

    initial
    begin
        dis_cnt = 0;
        sense_cmp_n = 1'b1;
        ref_cmp_n = 1'b1;
    end

    always @(posedge clk)
    begin
        #1;
        if (charge_sense || charge_ref)
        begin
            dis_cnt = 0;
            sense_cmp_n = 1'b1;
            ref_cmp_n = 1'b1;
        end
        else
        begin
            dis_cnt = dis_cnt + 1;
            ref_cmp_n = (dis_cnt < (ref_first ? WIN_CYC : LOSE_CYC));
            sense_cmp_n = (dis_cnt < (ref_first ? LOSE_CYC : WIN_CYC));
        end
    end
endmodule

// ---- dv/test_capacitive_touch_detect_logic.sv ----
// Purpose: self-checking bench for the touch detect core
// Assumes: rc model answers every discharge phase
// Notes: small run threshold and pulse time keep the run short
`timescale 1ns/1ps
module test_capacitive_touch_detect_logic;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    localparam int TH = 2;
    localparam int POUT = 50;
    localparam int OSC_HALF = 1250;
    localparam int LO = OSC_HALF - (OSC_HALF * ctd_pkg::MOD_PCT) / 100 - 2;
    localparam int HI = OSC_HALF + (OSC_HALF * ctd_pkg::MOD_PCT) / 100 + 2;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic overcurrent = 1'b0;
    logic ref_first = 1'b1;
    ctd_pkg::ctd_mode_type mode = ctd_pkg::MODE_PUSH;
    logic sense_cmp_n;
    logic ref_cmp_n;
    logic charge_sense;
    logic charge_ref;
    logic rate_node;
    logic cap_charge;
    logic cap_sink;
    ctd_pkg::ctd_dir_type last_pulse;
    logic switch_out;
    int err_total = 0;
    int compares = 0;
    int lens[$];
    int hi;

    always #20 ref_clk = ~ref_clk;

    ctd_core #(.THRESHOLD(TH), .PULSE_OUT_CYC(POUT), .OSC_HALF_CYC(OSC_HALF)) dut_u (
        .REF_CLK(ref_clk),
        .NRST(nrst),
        .SENSE_CMP_N(sense_cmp_n),
        .REF_CMP_N(ref_cmp_n),
        .OVERCURRENT(overcurrent),
        .MODE(mode),
        .CHARGE_SENSE(charge_sense),
        .CHARGE_REF(charge_ref),
        .SAMPLE_RATE_CAPACITOR_NODE(rate_node),
        .SENS_CAP_CHARGE(cap_charge),
        .SENS_CAP_SINK(cap_sink),
        .LAST_PULSE(last_pulse),
        .SWITCH_OUT(switch_out)
    );

    ctd_rc_model rc_u (
        .clk(ref_clk),
        .charge_sense(charge_sense),
        .charge_ref(charge_ref),
        .ref_first(ref_first),
        .sense_cmp_n(sense_cmp_n),
        .ref_cmp_n(ref_cmp_n)
    );

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_total++;
            $display("FAIL %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // one discharge race, judged on pulse width, decision and output
    task automatic do_sample(input logic up_win, input logic exp_out);
        int n;
        int wc;
        int ws;
        int skew;
        wc = 0;
        ws = 0;
        skew = 0;
        hi = 0;
        n = 0;
        tick(1);
        ref_first = up_win;
        while (charge_sense !== 1'b1 && n < 20000)
        begin
            tick(1);
            n++;
        end
        n = 0;
        while (charge_sense !== 1'b0 && n < 20000)
        begin
            tick(1);
            n++;
        end
        n = 0;
        while (charge_sense === 1'b0 && n < 20000)
        begin
            if (charge_ref !== charge_sense || rate_node !== charge_sense)
                skew++;
            if (cap_charge === 1'b1)
                wc++;
            if (cap_sink === 1'b1)
                ws++;
            if (switch_out === 1'b1)
                hi++;
            tick(1);
            n++;
        end
        lens.push_back(n);
        check("charge_skew", skew, 0);
        check("half_period_in_span", (n >= LO && n <= HI), 1);
        check("charge_width", wc, up_win ? ctd_pkg::UP_PULSE_CYC : 0);
        check("sink_width", ws, up_win ? 0 : ctd_pkg::DN_PULSE_CYC);
        check("last_pulse", last_pulse, {up_win, !up_win});
        check("switch_out", switch_out, exp_out);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        tick(3);
        check("reset_switch", switch_out, 0);
        check("reset_pulses", {cap_charge, cap_sink, last_pulse}, 0);
        nrst = 1'b1;
        tick(5);
        check("post_reset_switch", switch_out, 0);
    endtask

    task automatic t_push();
        do_sample(1'b1, 1'b0);
        do_sample(1'b0, 1'b0);
        do_sample(1'b1, 1'b0);
        do_sample(1'b1, 1'b1);
        overcurrent = 1'b1;
        tick(10);
        check("overcurrent_off", switch_out, 0);
        overcurrent = 1'b0;
        tick(10);
        check("overcurrent_clear", switch_out, 1);
        mode = ctd_pkg::ctd_mode_type'(2'b11);
        tick(5);
        check("mode_off", switch_out, 0);
        mode = ctd_pkg::MODE_PUSH;
        tick(5);
        check("mode_push_back", switch_out, 1);
        do_sample(1'b0, 1'b1);
        do_sample(1'b0, 1'b0);
    endtask

    task automatic t_toggle();
        mode = ctd_pkg::MODE_TOGGLE;
        do_sample(1'b1, 1'b0);
        do_sample(1'b1, 1'b1);
        do_sample(1'b0, 1'b1);
        do_sample(1'b0, 1'b1);
        do_sample(1'b1, 1'b1);
        do_sample(1'b1, 1'b0);
    endtask

    task automatic t_pulse();
        mode = ctd_pkg::MODE_PULSE;
        do_sample(1'b0, 1'b0);
        do_sample(1'b0, 1'b0);
        do_sample(1'b1, 1'b0);
        do_sample(1'b1, 1'b0);
        check("pulse_out_len", hi, POUT);
    endtask

    task automatic t_dither();
        int diff;
        diff = 0;
        foreach (lens[i])
            if (lens[i] != lens[0])
                diff = 1;
        check("dither_seen", diff, 1);
    endtask

    // ----------------------------------------
    // main and watchdog
    // ----------------------------------------
    initial
    begin
        t_reset();
        t_push();
        t_toggle();
        t_pulse();
        t_dither();
        wrap_up();
    end

    initial
    begin
        #(64'd40 * 64'd80000);
        err_total++;
        $display("FAIL watchdog expected done seen hang");
        wrap_up();
    end
endmodule
